// *** rtl/frh_fwd_unit.sv ***
// float pipeline result forwarding and move-to-cpu hazard control
`timescale 1ns/1ns
`include "frh_map.svh"
module frh_fwd_unit #(
  parameter int NREG = `FRH_NREG,
  parameter int W = `FRH_WIDTH,
  parameter bit FIX_E3_FORWARD = `FRH_FIX_DEFAULT
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic stall_in,
  input wire logic iss_valid,
  output logic iss_ready,
  input wire frh_pkg::frh_op_t iss_op,
  input wire logic [$clog2(NREG)-1:0] iss_dst,
  input wire logic [$clog2(NREG)-1:0] iss_src,
  input wire frh_pkg::frh_cpu_dst_t iss_cpu_dst,
  input wire logic [2:0] iss_aux_idx,
  input wire logic arith_valid,
  input wire logic [W-1:0] arith_result,
  output logic cpu_wr_valid,
  output frh_pkg::frh_cpu_dst_t cpu_wr_dst,
  output logic [2:0] cpu_wr_aux_idx,
  output logic [W-1:0] cpu_wr_data,
  output logic hazard_seen,
  output logic hazard_stalled,
  output logic spacing_err,
  output logic fwd_held
);
  import frh_pkg::*;

  localparam int IW = $clog2(NREG);

  // refuse shapes the indexing cannot serve, at elaboration
  if (NREG < 2 || (NREG & (NREG - 1)) != 0)
  begin : g_bad_nreg
    $error("frh_fwd_unit: NREG must be a power of two, at least 2");
  end
  if (W < 1)
  begin : g_bad_w
    $error("frh_fwd_unit: W must be at least 1");
  end

  // producer class: the two-cycle float ops
  function automatic logic is_2p(input frh_op_t op);
    is_2p = (op == frh_op_float_multiply) || (op == frh_op_float_add) ||
            (op == frh_op_float_subtract) || (op == frh_op_float_multiply_accumulate);
  endfunction

  // consumer class: any word_register_move out of the float file
  function automatic logic is_move(input frh_op_t op);
    is_move = (op == frh_op_move_to_cpu) || (op == frh_op_move_to_fpu);
  endfunction

  logic adv;
  logic en;
  logic stg_vld_q [`FRH_NSTAGE];
  frh_op_t stg_op_q [`FRH_NSTAGE];
  logic [IW-1:0] stg_dst_q [`FRH_NSTAGE];
  logic [IW-1:0] stg_src_q [`FRH_NSTAGE];
  frh_cpu_dst_t stg_cdst_q [`FRH_NSTAGE];
  logic [2:0] stg_aux_q [`FRH_NSTAGE];
  logic r2_fresh_q;
  logic [W-1:0] opnd_q;
  logic [W-1:0] pend_q;
  logic pend_vld_q;
  logic [W-1:0] rf_rd;
  logic [W-1:0] fwd_val;
  logic [W-1:0] opnd_d;
  logic sample;
  logic prod_e3;
  logic prod_near;
  logic fwd_lost;
  logic rf_wa_en;
  logic rf_wb_en;
  logic cpu_wr_valid_q;
  frh_cpu_dst_t cpu_wr_dst_q;
  logic [2:0] cpu_wr_aux_q;
  logic [W-1:0] cpu_wr_data_q;
  logic hazard_seen_q;
  logic hazard_stalled_q;
  logic spacing_err_q;

  // clock enable freezes all; a stall freezes the stages only
  assign en = clk_en;
  assign adv = clk_en && !stall_in;
  assign iss_ready = adv;

  // entry stage takes the issued instruction
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stg_vld_q[`FRH_ST_R1] <= 1'b0;
      stg_op_q[`FRH_ST_R1] <= frh_op_none;
      stg_dst_q[`FRH_ST_R1] <= '0;
      stg_src_q[`FRH_ST_R1] <= '0;
      stg_cdst_q[`FRH_ST_R1] <= frh_dst_accumulator_reg;
      stg_aux_q[`FRH_ST_R1] <= 3'h0;
    end
    else if (adv)
    begin
      stg_vld_q[`FRH_ST_R1] <= iss_valid;
      stg_op_q[`FRH_ST_R1] <= iss_op;
      stg_dst_q[`FRH_ST_R1] <= iss_dst;
      stg_src_q[`FRH_ST_R1] <= iss_src;
      stg_cdst_q[`FRH_ST_R1] <= iss_cpu_dst;
      stg_aux_q[`FRH_ST_R1] <= iss_aux_idx;
    end
  end

  // later stages shift only when the pipeline advances
  for (genvar s = 1; s < `FRH_NSTAGE; s++)
  begin : g_stage
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        stg_vld_q[s] <= 1'b0;
        stg_op_q[s] <= frh_op_none;
        stg_dst_q[s] <= '0;
        stg_src_q[s] <= '0;
        stg_cdst_q[s] <= frh_dst_accumulator_reg;
        stg_aux_q[s] <= 3'h0;
      end
      else if (adv)
      begin
        stg_vld_q[s] <= stg_vld_q[s-1];
        stg_op_q[s] <= stg_op_q[s-1];
        stg_dst_q[s] <= stg_dst_q[s-1];
        stg_src_q[s] <= stg_src_q[s-1];
        stg_cdst_q[s] <= stg_cdst_q[s-1];
        stg_aux_q[s] <= stg_aux_q[s-1];
      end
    end
  end

  // marks the first cycle of a new read_stage_two occupant
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      r2_fresh_q <= 1'b0;
    else if (en)
      r2_fresh_q <= adv;
  end

  // pending two-cycle result, held until the producer leaves exec_stage_three
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_q <= W'(`FRH_DATA_RST);
      pend_vld_q <= 1'b0;
    end
    else if (en)
    begin
      if (arith_valid)
      begin
        pend_q <= arith_result;
        pend_vld_q <= 1'b1;
      end
      else if (adv)
        pend_vld_q <= 1'b0;
    end
  end

  // forwarded value: live result first, else the held copy
  assign fwd_val = arith_valid ? arith_result : pend_q;

  // hazard detection at the read_stage_two sample point
  assign sample = en && r2_fresh_q && stg_vld_q[`FRH_ST_R2] && is_move(stg_op_q[`FRH_ST_R2]);
  assign prod_e3 = stg_vld_q[`FRH_ST_E3] && is_2p(stg_op_q[`FRH_ST_E3]) &&
                   stg_dst_q[`FRH_ST_E3] == stg_src_q[`FRH_ST_R2];
  assign prod_near = (stg_vld_q[`FRH_ST_E1] && is_2p(stg_op_q[`FRH_ST_E1]) &&
                      stg_dst_q[`FRH_ST_E1] == stg_src_q[`FRH_ST_R2]) ||
                     (stg_vld_q[`FRH_ST_E2] && is_2p(stg_op_q[`FRH_ST_E2]) &&
                      stg_dst_q[`FRH_ST_E2] == stg_src_q[`FRH_ST_R2]);

  // original silicon drops forwarding to a cpu move under a stall
  assign fwd_lost = !FIX_E3_FORWARD && stall_in &&
                    stg_op_q[`FRH_ST_R2] == frh_op_move_to_cpu;

  // operand chosen for the move; float-to-float always forwards
  always_comb
  begin
    opnd_d = rf_rd;
    if (prod_e3 && !fwd_lost)
      opnd_d = fwd_val;
  end

  // the move's operand is captured once and then held
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      opnd_q <= W'(`FRH_DATA_RST);
    else if (sample)
      opnd_q <= opnd_d;
  end

  // hazard reporting pulses
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hazard_seen_q <= 1'b0;
      hazard_stalled_q <= 1'b0;
      spacing_err_q <= 1'b0;
    end
    else if (en)
    begin
      hazard_seen_q <= sample && prod_e3 && stg_op_q[`FRH_ST_R2] == frh_op_move_to_cpu;
      hazard_stalled_q <= sample && prod_e3 && stall_in &&
                          stg_op_q[`FRH_ST_R2] == frh_op_move_to_cpu;
      spacing_err_q <= sample && prod_near;
    end
  end

  // writebacks: producer leaves exec_stage_three, move leaves first exec stage
  assign rf_wa_en = adv && stg_vld_q[`FRH_ST_E3] && is_2p(stg_op_q[`FRH_ST_E3]);
  assign rf_wb_en = adv && stg_vld_q[`FRH_ST_E1] && stg_op_q[`FRH_ST_E1] == frh_op_move_to_fpu;

  frh_regfile #(
    .NREG(NREG),
    .W(W)
  ) u_regfile (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .en(en),
    .wa_en(rf_wa_en),
    .wa_idx(stg_dst_q[`FRH_ST_E3]),
    .wa_data(fwd_val),
    .wb_en(rf_wb_en),
    .wb_idx(stg_dst_q[`FRH_ST_E1]),
    .wb_data(opnd_q),
    .rd_idx(stg_src_q[`FRH_ST_R2]),
    .rd_data(rf_rd)
  );

  // move into the main cpu register set
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cpu_wr_valid_q <= 1'b0;
      cpu_wr_dst_q <= frh_dst_accumulator_reg;
      cpu_wr_aux_q <= 3'h0;
      cpu_wr_data_q <= W'(`FRH_DATA_RST);
    end
    else if (en)
    begin
      cpu_wr_valid_q <= adv && stg_vld_q[`FRH_ST_E1] && stg_op_q[`FRH_ST_E1] == frh_op_move_to_cpu;
      if (adv && stg_vld_q[`FRH_ST_E1] && stg_op_q[`FRH_ST_E1] == frh_op_move_to_cpu)
      begin
        cpu_wr_dst_q <= stg_cdst_q[`FRH_ST_E1];
        cpu_wr_aux_q <= stg_aux_q[`FRH_ST_E1];
        cpu_wr_data_q <= opnd_q;
      end
    end
  end

  // outputs
  assign cpu_wr_valid = cpu_wr_valid_q;
  assign cpu_wr_dst = cpu_wr_dst_q;
  assign cpu_wr_aux_idx = cpu_wr_aux_q;
  assign cpu_wr_data = cpu_wr_data_q;
  assign hazard_seen = hazard_seen_q;
  assign hazard_stalled = hazard_stalled_q;
  assign spacing_err = spacing_err_q;
  assign fwd_held = pend_vld_q;
endmodule // frh_fwd_unit

// *** rtl/frh_map.svh ***
// constants and field positions for the float result forwarding hazard unit
`ifndef FRH_MAP_SVH
`define FRH_MAP_SVH
`define FRH_NREG 8
`define FRH_WIDTH 32
`define FRH_NSTAGE 5
`define FRH_ST_R1 0
`define FRH_ST_R2 1
`define FRH_ST_E1 2
`define FRH_ST_E2 3
`define FRH_ST_E3 4
`define FRH_DELAY_SLOTS 3
`define FRH_FIX_DEFAULT 1'b1
`define FRH_DATA_RST 32'h0000_0000
`endif

// *** rtl/frh_pkg.sv ***
// types shared by the float result forwarding hazard unit
package frh_pkg;
  // instruction classes seen by the forwarding logic
  typedef enum logic [2:0] {
    frh_op_none,
    frh_op_float_multiply,
    frh_op_float_add,
    frh_op_float_subtract,
    frh_op_float_multiply_accumulate,
    frh_op_move_to_cpu,
    frh_op_move_to_fpu,
    frh_op_other
  } frh_op_t;
  // main cpu destinations of a word_register_move
  typedef enum logic [1:0] {
    frh_dst_accumulator_reg,
    frh_dst_product_reg,
    frh_dst_multiplicand_reg,
    frh_dst_aux_pointer
  } frh_cpu_dst_t;
endpackage

// *** rtl/frh_regfile.sv ***
// float register file in flip-flops, two write ports and one read port
`timescale 1ns/1ns
module frh_regfile #(
  parameter int NREG = 8,
  parameter int W = 32
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic wa_en,
  input wire logic [$clog2(NREG)-1:0] wa_idx,
  input wire logic [W-1:0] wa_data,
  input wire logic wb_en,
  input wire logic [$clog2(NREG)-1:0] wb_idx,
  input wire logic [W-1:0] wb_data,
  input wire logic [$clog2(NREG)-1:0] rd_idx,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] reg_q [NREG];

  // one flop word per register; port b is the younger writer and wins
  for (genvar i = 0; i < NREG; i++)
  begin : g_reg
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
        reg_q[i] <= '0;
      else if (en && wb_en && wb_idx == i)
        reg_q[i] <= wb_data;
      else if (en && wa_en && wa_idx == i)
        reg_q[i] <= wa_data;
    end
  end

  // combinational read
  assign rd_data = reg_q[rd_idx];
endmodule // frh_regfile

// *** bench/frh_fwd_unit_assertions.sv ***
// concurrent checks on the forwarding unit ports
`timescale 1ns/1ns
module frh_fwd_unit_assertions #(
  parameter int W = 32
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic stall_in,
  input wire logic iss_ready,
  input wire logic arith_valid,
  input wire logic [W-1:0] arith_result,
  input wire logic cpu_wr_valid,
  input wire logic [W-1:0] cpu_wr_data,
  input wire logic hazard_seen,
  input wire logic hazard_stalled,
  input wire logic spacing_err,
  input wire logic fwd_held
);
  logic [W-1:0] res_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // last result offered by the arithmetic unit
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      res_q <= '0;
    else if (arith_valid && clk_en)
      res_q <= arith_result;
  end
  property p_ready; iss_ready == (clk_en && !stall_in); endproperty
  a_ready: assert property (p_ready) else $error("ready wrong");
  property p_stall_wr; clk_en && stall_in |=> !cpu_wr_valid; endproperty
  a_stall_wr: assert property (p_stall_wr) else $error("write in stall");
  property p_freeze; !clk_en |=> $stable(cpu_wr_valid) && $stable(cpu_wr_data) && $stable(fwd_held); endproperty
  a_freeze: assert property (p_freeze) else $error("moved while frozen");
  property p_stalled; hazard_stalled |-> hazard_seen && $past(stall_in); endproperty
  a_stalled: assert property (p_stalled) else $error("stall flag wrong");
  property p_fwd; hazard_seen && !hazard_stalled && iss_ready |=> cpu_wr_valid && cpu_wr_data == res_q; endproperty
  a_fwd: assert property (p_fwd) else $error("forward write wrong");
  property p_held; arith_valid && clk_en && stall_in |=> fwd_held; endproperty
  a_held: assert property (p_held) else $error("result not held");
  property p_held_stall; fwd_held && !iss_ready |=> fwd_held; endproperty
  a_held_stall: assert property (p_held_stall) else $error("hold lost");
  property p_spacing; spacing_err |-> !hazard_seen; endproperty
  a_spacing: assert property (p_spacing) else $error("spacing and hazard");
  c_stl: cover property (hazard_stalled);
  c_sp: cover property (spacing_err);
  c_frz: cover property (cpu_wr_valid ##1 !clk_en);
  c_fwd: cover property (hazard_seen && !hazard_stalled);
endmodule // frh_fwd_unit_assertions
bind frh_fwd_unit frh_fwd_unit_assertions #(.W(W)) u_chk (.core_clk(core_clk), .arst_n(arst_n),
  .clk_en(clk_en), .stall_in(stall_in), .iss_ready(iss_ready), .arith_valid(arith_valid),
  .arith_result(arith_result), .cpu_wr_valid(cpu_wr_valid), .cpu_wr_data(cpu_wr_data),
  .hazard_seen(hazard_seen), .hazard_stalled(hazard_stalled), .spacing_err(spacing_err), .fwd_held(fwd_held));

// *** bench/frh_cpu_model.sv ***
// main cpu register set taking moves from the float pipeline
`timescale 1ns/1ns
module frh_cpu_model (
  input wire logic core_clk,
  input wire logic en,
  input wire logic wr_valid,
  input wire frh_pkg::frh_cpu_dst_t wr_dst,
  input wire logic [2:0] wr_aux_idx,
  input wire logic [31:0] wr_data,
  output logic [31:0] regs_q [11]
);
  import frh_pkg::*;
  // accumulator, product, multiplicand, then aux pointers zero to seven
  always_ff @(posedge core_clk)
  begin
    if (wr_valid && en)
      regs_q[wr_dst == frh_dst_aux_pointer ? 4'(3 + wr_aux_idx) : 4'(wr_dst)] <= wr_data;
  end
endmodule // frh_cpu_model

// *** bench/test_fpu_result_forwarding_hazard.sv ***
// testbench for the float result forwarding unit
`timescale 1ns/1ns
module test_fpu_result_forwarding_hazard;
  import frh_pkg::*;
  logic core_clk = 0, arst_n = 0, clk_en = 1, stall_in = 0, iss_valid = 0, arith_valid = 0;
  frh_op_t iss_op = frh_op_none;
  logic [2:0] iss_dst = 0, iss_src = 0, iss_aux_idx = 0, cpu_wr_aux_idx;
  frh_cpu_dst_t iss_cpu_dst = frh_dst_accumulator_reg, cpu_wr_dst;
  logic [31:0] arith_result = 0, cpu_wr_data;
  logic [31:0] regs [11];
  logic iss_ready, cpu_wr_valid, hazard_seen, hazard_stalled, spacing_err, fwd_held;
  int n_errors = 0, checked = 0, n_seen, n_stl, n_sp, n_wr;
  always #25 core_clk = ~core_clk;
  frh_fwd_unit DUT (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .stall_in(stall_in),
    .iss_valid(iss_valid), .iss_ready(iss_ready), .iss_op(iss_op), .iss_dst(iss_dst), .iss_src(iss_src),
    .iss_cpu_dst(iss_cpu_dst), .iss_aux_idx(iss_aux_idx), .arith_valid(arith_valid),
    .arith_result(arith_result), .cpu_wr_valid(cpu_wr_valid), .cpu_wr_dst(cpu_wr_dst),
    .cpu_wr_aux_idx(cpu_wr_aux_idx), .cpu_wr_data(cpu_wr_data), .hazard_seen(hazard_seen),
    .hazard_stalled(hazard_stalled), .spacing_err(spacing_err), .fwd_held(fwd_held));
  frh_cpu_model u_cpu (.core_clk(core_clk), .en(clk_en), .wr_valid(cpu_wr_valid), .wr_dst(cpu_wr_dst),
    .wr_aux_idx(cpu_wr_aux_idx), .wr_data(cpu_wr_data), .regs_q(regs));
  // tally the design's pulses on enabled edges
  always @(posedge core_clk)
  begin
    if (clk_en)
    begin
      n_seen += hazard_seen === 1'b1;
      n_stl += hazard_stalled === 1'b1;
      n_sp += spacing_err === 1'b1;
      n_wr += cpu_wr_valid === 1'b1;
    end
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one issue slot, inputs change just after the edge
  task automatic slot(frh_op_t op, logic [2:0] d, logic [2:0] s, logic st, logic av);
    @(posedge core_clk);
    #1;
    iss_valid = op != frh_op_none;
    iss_op = op;
    iss_dst = d;
    iss_src = s;
    stall_in = st;
    arith_valid = av;
  endtask
  task automatic idle(int n);
    repeat (n) slot(frh_op_none, 0, 0, 0, 0);
  endtask
  task automatic clr();
    n_seen = 0;
    n_stl = 0;
    n_sp = 0;
    n_wr = 0;
  endtask
  // producer then dependent cpu move three slots later, optional stall or freeze
  task automatic t_hazard(frh_op_t op, frh_cpu_dst_t cd, logic [2:0] ax, logic st, logic frz, logic [31:0] res);
    clr();
    iss_cpu_dst = cd;
    iss_aux_idx = ax;
    slot(op, 3'h6, 3'h0, 0, 0);
    idle(2);
    slot(frh_op_move_to_cpu, 3'h0, 3'h6, 0, 0);
    idle(1);
    arith_result = res;
    slot(frh_op_none, 0, 0, st, 1);
    if (st)
    begin
      slot(frh_op_none, 0, 0, 1, 0);
      chk(fwd_held, 1);
    end
    for (int k = 0; k < 8; k++)
    begin
      slot(frh_op_none, 0, 0, 0, 0);
      clk_en = !(frz && k inside {[2:3]});
    end
    chk(regs[cd == frh_dst_aux_pointer ? 3 + ax : cd], res);
    chk(n_seen, 1);
    chk(n_stl, st);
    chk(n_wr, 1);
    $display("t_hazard done");
  endtask
  // float to float move under stall, then read back through a cpu move
  task automatic t_f2f(logic [31:0] res);
    clr();
    iss_cpu_dst = frh_dst_accumulator_reg;
    slot(frh_op_float_add, 3'h6, 3'h0, 0, 0);
    idle(2);
    slot(frh_op_move_to_fpu, 3'h2, 3'h6, 0, 0);
    idle(1);
    arith_result = res;
    slot(frh_op_none, 0, 0, 1, 1);
    slot(frh_op_none, 0, 0, 1, 0);
    idle(4);
    slot(frh_op_move_to_cpu, 3'h0, 3'h2, 0, 0);
    idle(6);
    chk(regs[0], res);
    chk(n_wr, 1);
    chk(n_seen, 0);
    $display("t_f2f done");
  endtask
  // dependent move one slot too early
  task automatic t_spacing(logic [31:0] res);
    clr();
    slot(frh_op_float_subtract, 3'h5, 3'h0, 0, 0);
    idle(1);
    slot(frh_op_move_to_cpu, 3'h0, 3'h5, 0, 0);
    idle(2);
    arith_result = res;
    slot(frh_op_none, 0, 0, 0, 1);
    idle(6);
    chk(n_sp, 1);
    chk(n_seen, 0);
    $display("t_spacing done");
  endtask
  task automatic conclude();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // reset, then every two-cycle op and every cpu destination kind
  initial
  begin
    repeat (16) @(posedge core_clk);
    #1;
    arst_n = 1;
    for (int i = 0; i < 5; i++)
      t_hazard(frh_op_t'(1 + i % 4), frh_cpu_dst_t'(i > 2 ? 3 : i), i == 3 ? 3'h0 : 3'h7, i[0], i == 4, 32'h1000 + i);
    t_f2f(32'h2000);
    t_spacing(32'h3000);
    conclude();
  end
endmodule // test_fpu_result_forwarding_hazard
